// *** core/acgtp_pkg.sv ***
// constants, codes and the gain table for the channel gain and pattern block
// Operation
// - gain code steps half dB, 0 to 6
// - skip bit bypasses the channel gain stage
// - select 000 data, 001 zeros, 010 ones
// - 11-bit toggle alternates 10101010101, 01010101010
// - 14-bit toggle alternates 01010101010101, complement
// - 11-bit ramp steps every eighth sample
// - 14-bit ramp steps every sample
// - custom pattern, 11-bit uses bits 13:3
// - offset fix puts mid-scale on 1023
// - upper pattern register gives bits 13:8
// - feature enable bit gates gain and offset
// - lower pattern register gives bits 7:0
package acgtp_pkg;

    // ========================================================
    // widths and register map
    localparam int NUM_CH = 4;
    localparam int DW     = 14;
    localparam logic [7:0] OFS_CHAN [NUM_CH] = '{8'h2B, 8'h25, 8'h37, 8'h31};
    localparam logic [7:0] OFS_MIDFIX  = 8'h3D;
    localparam logic [7:0] OFS_PAT_HI  = 8'h3F;
    localparam logic [7:0] OFS_PAT_LO  = 8'h40;
    localparam logic [7:0] OFS_DIG_EN  = 8'h42;
    localparam logic [7:0] OFS_BURST   = 8'h44;
    localparam logic [7:0] RST_VAL     = 8'h00;
    localparam logic [7:0] MASK_MIDFIX = 8'h20;
    localparam logic [7:0] MASK_PAT_HI = 8'h3F;
    localparam logic [7:0] MASK_DIG_EN = 8'h0F;
    localparam logic [7:0] MASK_BURST  = 8'hC5;

    // ========================================================
    // field positions
    localparam int BIT_MIDFIX   = 5;
    localparam int BIT_DIG_EN   = 3;
    localparam int BIT_BURST_AB = 6;
    localparam int BIT_BURST_CD = 7;
    localparam int BIT_SKIP     = 3;

    // ========================================================
    // pattern select codes and words
    localparam logic [2:0] SEL_NORMAL = 3'h0;
    localparam logic [2:0] SEL_ZEROS  = 3'h1;
    localparam logic [2:0] SEL_ONES   = 3'h2;
    localparam logic [2:0] SEL_TOGGLE = 3'h3;
    localparam logic [2:0] SEL_RAMP   = 3'h4;
    localparam logic [2:0] SEL_CUSTOM = 3'h5;
    localparam logic [13:0] ONES_11 = 14'h07FF;
    localparam logic [13:0] ONES_14 = 14'h3FFF;
    localparam logic [13:0] TOG_11A = 14'h0555;
    localparam logic [13:0] TOG_11B = 14'h02AA;
    localparam logic [13:0] TOG_14A = 14'h1555;
    localparam logic [13:0] TOG_14B = 14'h2AAA;
    localparam logic [2:0]  RAMP_DIV_LAST = 3'h7;
    localparam logic [3:0]  GAIN_MAX = 4'hC;
    localparam logic signed [16:0] SAT_HI = 17'sh01FFF;
    localparam logic signed [16:0] SAT_LO = -17'sh02000;

    // gain factor in units of 1/4096, clamped at the top code
    function automatic logic [13:0] acgtp_gain_coef(input logic [3:0] code);
        logic [3:0] c;
        c = (code > GAIN_MAX) ? GAIN_MAX : code;
        unique case (c)
            4'h0: return 14'h1000;
            4'h1: return 14'h10F3;
            4'h2: return 14'h11F4;
            4'h3: return 14'h1304;
            4'h4: return 14'h1425;
            4'h5: return 14'h1556;
            4'h6: return 14'h169A;
            4'h7: return 14'h17F1;
            4'h8: return 14'h195C;
            4'h9: return 14'h1ADD;
            4'hA: return 14'h1C74;
            4'hB: return 14'h1E24;
            default: return 14'h1FED;
        endcase
    endfunction

endpackage

// *** core/acgtp_chan.sv ***
// one channel: gain, offset fix and test pattern selection
`timescale 1ns/100ps
`default_nettype none
module acgtp_chan import acgtp_pkg::*; (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          smp_en_in,
    input  wire logic [13:0]   adc_in,
    input  wire logic [7:0]    ctrl_in,
    input  wire logic [13:0]   pat_in,
    input  wire logic          dig_en_in,
    input  wire logic          midfix_in,
    input  wire logic          burst_in,
    output logic      [13:0]   data_out
);
    logic [13:0]        data_reg, data_next, ramp_reg, ramp_next, proc;
    logic [2:0]         div_reg, div_next, sel;
    logic               tog_reg, tog_next;
    logic [10:0]        w11;
    logic signed [13:0] sv;
    logic signed [28:0] prod;
    logic signed [16:0] scaled;

    // ========================================================
    // gain and offset path
    always_comb begin
        sel    = ctrl_in[2:0];
        sv     = signed'({~adc_in[13], adc_in[12:0]});
        prod   = sv * signed'({1'b0, acgtp_gain_coef(ctrl_in[7:4])});
        scaled = prod[28:12];
        if (scaled > SAT_HI)
            scaled = SAT_HI;
        if (scaled < SAT_LO)
            scaled = SAT_LO;
        if (dig_en_in && !ctrl_in[BIT_SKIP]) begin
            proc = {~scaled[13], scaled[12:0]};
        end else begin
            proc = adc_in;
        end
        w11 = proc[13:3];
        if (dig_en_in && midfix_in && w11 != 11'h000) begin
            w11 = w11 - 11'h001;
        end
    end

    // ========================================================
    // pattern generators and output select
    always_comb begin
        data_next = data_reg;
        ramp_next = ramp_reg;
        div_next  = div_reg;
        tog_next  = tog_reg;
        if (smp_en_in) begin
            tog_next  = (sel == SEL_TOGGLE) ? ~tog_reg : 1'b0;
            ramp_next = 14'h0000;
            div_next  = 3'h0;
            if (sel == SEL_RAMP && burst_in) begin
                ramp_next = ramp_reg + 14'h0001;
            end else if (sel == SEL_RAMP) begin
                div_next  = div_reg + 3'h1;
                ramp_next = ramp_reg;
                if (div_reg == RAMP_DIV_LAST) begin
                    ramp_next = {3'h0, ramp_reg[10:0] + 11'h001};
                end
            end
            unique case (sel)
                SEL_ZEROS:  data_next = 14'h0000;
                SEL_ONES:   data_next = burst_in ? ONES_14 : ONES_11;
                SEL_TOGGLE: begin
                    if (burst_in) begin
                        data_next = tog_reg ? TOG_14B : TOG_14A;
                    end else begin
                        data_next = tog_reg ? TOG_11B : TOG_11A;
                    end
                end
                SEL_RAMP:   data_next = ramp_reg;
                SEL_CUSTOM: begin
                    data_next = burst_in ? pat_in : {3'h0, pat_in[13:3]};
                end
                default: begin
                    data_next = burst_in ? proc : {3'h0, w11};
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_reg <= 14'h0000;
            ramp_reg <= 14'h0000;
            div_reg  <= 3'h0;
            tog_reg  <= 1'b0;
        end else begin
            data_reg <= data_next;
            ramp_reg <= ramp_next;
            div_reg  <= div_next;
            tog_reg  <= tog_next;
        end
    end

    assign data_out = data_reg;

    // ========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_ramp14;
        smp_en_in && sel == SEL_RAMP && burst_in;
    endsequence

    a_zero_pattern: assert property (
        smp_en_in && sel == SEL_ZEROS |=> data_out == 14'h0000)
        else $error("zero pattern not driven");
    a_ones_pattern: assert property (
        smp_en_in && sel == SEL_ONES && !burst_in |=> data_out == ONES_11)
        else $error("ones pattern wrong");
    a_toggle_alt: assert property (
        smp_en_in && sel == SEL_TOGGLE && !burst_in && !tog_reg
        |=> data_out == TOG_11A && tog_reg)
        else $error("toggle sequence wrong");
    a_ramp_step: assert property (
        s_ramp14 |=> ramp_reg == $past(ramp_reg) + 14'h0001)
        else $error("burst ramp did not step");
    a_ramp_hold: assert property (
        smp_en_in && sel == SEL_RAMP && !burst_in && div_reg != RAMP_DIV_LAST
        |=> ramp_reg == $past(ramp_reg))
        else $error("short ramp stepped early");
    a_custom_out: assert property (
        smp_en_in && sel == SEL_CUSTOM && !burst_in
        |=> data_out == {3'h0, $past(pat_in[13:3])})
        else $error("custom pattern wrong");
    a_bypass_pass: assert property (
        smp_en_in && sel == SEL_NORMAL && burst_in && ctrl_in[BIT_SKIP]
        |=> data_out == $past(adc_in))
        else $error("bypass altered data");
    // codes above the top one must never scale past twice the input
    a_gain_clamp: assert property (
        ctrl_in[7:4] > GAIN_MAX && !sv[13]
        |-> scaled <= signed'({3'b000, sv, 1'b0}))
        else $error("gain above top setting");
endmodule // acgtp_chan
`default_nettype wire

// *** core/acgtp_top.sv ***
// register bank, sample clock detection and four channel processors
`timescale 1ns/100ps
`default_nettype none
module acgtp_top import acgtp_pkg::*; (
    input  wire logic          SYS_CLK_IN,
    input  wire logic          RST_IN,
    input  wire logic          SAMPLE_CLK_IN,
    input  wire logic [7:0]    REG_ADDR_IN,
    input  wire logic [7:0]    REG_WDATA_IN,
    input  wire logic          REG_WR_IN,
    output logic      [7:0]    REG_RDATA_OUT,
    input  wire logic [55:0]   ADC_DATA_IN,
    output logic      [55:0]   CH_DATA_OUT,
    output logic               CH_VALID_OUT
);
    logic [7:0] ctrl_reg [NUM_CH];
    logic [7:0] ctrl_next [NUM_CH];
    logic [7:0] midfix_reg, midfix_next, pat_hi_reg, pat_hi_next;
    logic [7:0] pat_lo_reg, pat_lo_next, dig_reg, dig_next;
    logic [7:0] burst_reg, burst_next, rdata_reg, rdata_next;
    logic [2:0] sync_reg, sync_next;
    logic       lvl_reg, lvl_next, valid_reg, smp_en;
    logic [13:0] pattern;

    // ========================================================
    // register writes and reads
    function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                          input logic [7:0] c [NUM_CH],
                                          input logic [7:0] m,
                                          input logic [7:0] h,
                                          input logic [7:0] l,
                                          input logic [7:0] d,
                                          input logic [7:0] b);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == OFS_CHAN[i])
                v = c[i];
        end
        if (a == OFS_MIDFIX)
            v = m;
        if (a == OFS_PAT_HI)
            v = h;
        if (a == OFS_PAT_LO)
            v = l;
        if (a == OFS_DIG_EN)
            v = d;
        if (a == OFS_BURST)
            v = b;
        return v;
    endfunction

    always_comb begin
        midfix_next = midfix_reg;
        pat_hi_next = pat_hi_reg;
        pat_lo_next = pat_lo_reg;
        dig_next    = dig_reg;
        burst_next  = burst_reg;
        for (int i = 0; i < NUM_CH; i++) begin
            ctrl_next[i] = ctrl_reg[i];
            if (REG_WR_IN && REG_ADDR_IN == OFS_CHAN[i])
                ctrl_next[i] = REG_WDATA_IN;
        end
        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                OFS_MIDFIX: midfix_next = REG_WDATA_IN & MASK_MIDFIX;
                OFS_PAT_HI: pat_hi_next = REG_WDATA_IN & MASK_PAT_HI;
                OFS_PAT_LO: pat_lo_next = REG_WDATA_IN;
                OFS_DIG_EN: dig_next    = REG_WDATA_IN & MASK_DIG_EN;
                OFS_BURST:  burst_next  = REG_WDATA_IN & MASK_BURST;
                default:    ;
            endcase
        end
        rdata_next = rd_mux(REG_ADDR_IN, ctrl_reg, midfix_reg, pat_hi_reg,
                            pat_lo_reg, dig_reg, burst_reg);
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < NUM_CH; i++)
                ctrl_reg[i] <= RST_VAL;
            midfix_reg <= RST_VAL;
            pat_hi_reg <= RST_VAL;
            pat_lo_reg <= RST_VAL;
            dig_reg    <= RST_VAL;
            burst_reg  <= RST_VAL;
            rdata_reg  <= 8'h00;
        end else begin
            for (int i = 0; i < NUM_CH; i++)
                ctrl_reg[i] <= ctrl_next[i];
            midfix_reg <= midfix_next;
            pat_hi_reg <= pat_hi_next;
            pat_lo_reg <= pat_lo_next;
            dig_reg    <= dig_next;
            burst_reg  <= burst_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign REG_RDATA_OUT = rdata_reg;
    assign pattern = {pat_hi_reg[5:0], pat_lo_reg};

    // ========================================================
    // sample clock: three stages, level moves when the last two agree
    always_comb begin
        sync_next = {sync_reg[1:0], SAMPLE_CLK_IN};
        lvl_next  = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
        smp_en    = lvl_next && !lvl_reg;
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sync_reg  <= 3'h0;
            lvl_reg   <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            sync_reg  <= sync_next;
            lvl_reg   <= lvl_next;
            valid_reg <= smp_en;
        end
    end

    assign CH_VALID_OUT = valid_reg;

    // ========================================================
    // channel processors, index 0..3 = channels a..d
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        acgtp_chan u_chan (
            .clk_in    (SYS_CLK_IN),
            .rst_in    (RST_IN),
            .smp_en_in (smp_en),
            .adc_in    (ADC_DATA_IN[g*DW +: DW]),
            .ctrl_in   (ctrl_reg[g]),
            .pat_in    (pattern),
            .dig_en_in (dig_reg[BIT_DIG_EN]),
            .midfix_in (midfix_reg[BIT_MIDFIX]),
            .burst_in  (burst_reg[(g < 2) ? BIT_BURST_AB : BIT_BURST_CD]),
            .data_out  (CH_DATA_OUT[g*DW +: DW])
        );
    end

    // ========================================================
    // checks
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_pat_hi_mask: assert property (
        REG_WR_IN && REG_ADDR_IN == OFS_PAT_HI
        |=> pat_hi_reg == ($past(REG_WDATA_IN) & MASK_PAT_HI))
        else $error("upper pattern write wrong");
    a_feature_bit: assert property (
        REG_WR_IN && REG_ADDR_IN == OFS_DIG_EN
        |=> dig_reg[BIT_DIG_EN] == $past(REG_WDATA_IN[BIT_DIG_EN]))
        else $error("feature enable not stored");
    a_valid_pulse: assert property (
        CH_VALID_OUT |=> !CH_VALID_OUT ##1 !CH_VALID_OUT)
        else $error("sample pulse too long");
endmodule // acgtp_top
`default_nettype wire

// *** test/acgtp_rx_model.sv ***
// receiving logic model: captures every processed sample word
`timescale 1ns/100ps
`default_nettype none
module acgtp_rx_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        valid_in,
    input  wire logic [55:0] data_in,
    output logic      [55:0] word_out,
    output logic      [31:0] count_out
);
    // ========================================================
    // capture
    logic [55:0] word_reg;
    logic [55:0] word_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;

    // one word per valid pulse, taken on the pulse's own edge
    always_comb begin
        word_next  = word_reg;
        count_next = count_reg;
        if (valid_in) begin
            word_next  = data_in;
            count_next = count_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_reg  <= '0;
            count_reg <= '0;
        end else begin
            word_reg  <= word_next;
            count_reg <= count_next;
        end
    end

    assign word_out  = word_reg;
    assign count_out = count_reg;
endmodule // acgtp_rx_model
`default_nettype wire

// *** test/test_acgtp_top.sv ***
// self-checking bench for the channel gain and pattern block
`timescale 1ns/100ps
`default_nettype none
module test_acgtp_top import acgtp_pkg::*;;
    typedef struct {
        logic [7:0]        c;
        logic [7:0]        b;
        logic [7:0]        d;
        logic [7:0]        m;
        logic [13:0]       a;
        logic [2:0][13:0]  e;
    } acgtp_row_t;

    logic        sys_clk, rst, smp_clk, smp_run, wr_en, valid;
    logic [7:0]  addr, wdata, rdata;
    logic [55:0] adc, dout, rx_word, w;
    logic [31:0] rx_count;
    int          err_count, check_count;

    // ========================================================
    // ordinary cases: select, mode and gain settings
    acgtp_row_t rows [17] = '{
        '{8'h01, 8'h00, 8'h00, 8'h00, 14'h2400, {14'h0, 14'h0, 14'h0}},
        '{8'h03, 8'h00, 8'h00, 8'h00, 14'h2400, {14'h555, 14'h2AA, 14'h555}},
        '{8'h02, 8'h00, 8'h00, 8'h00, 14'h2400, {3{14'h7FF}}},
        '{8'h03, 8'hC0, 8'h00, 8'h00, 14'h2400, {14'h1555, 14'h2AAA, 14'h1555}},
        '{8'h02, 8'hC0, 8'h00, 8'h00, 14'h2400, {3{14'h3FFF}}},
        '{8'h04, 8'hC0, 8'h00, 8'h00, 14'h2400, {14'h0, 14'h1, 14'h2}},
        '{8'h05, 8'h00, 8'h00, 8'h00, 14'h2400, {3{14'h54B}}},
        '{8'h05, 8'hC0, 8'h00, 8'h00, 14'h2400, {3{14'h2A5C}}},
        '{8'hC0, 8'hC0, 8'h00, 8'h00, 14'h2400, {3{14'h2400}}},
        '{8'hC0, 8'hC0, 8'h08, 8'h00, 14'h2400, {3{14'h27FB}}},
        '{8'h20, 8'hC0, 8'h08, 8'h00, 14'h2400, {3{14'h247D}}},
        '{8'hC8, 8'hC0, 8'h08, 8'h00, 14'h2400, {3{14'h2400}}},
        '{8'hF0, 8'hC0, 8'h08, 8'h00, 14'h2400, {3{14'h27FB}}},
        '{8'h06, 8'hC0, 8'h00, 8'h00, 14'h2400, {3{14'h2400}}},
        '{8'h07, 8'hC0, 8'h00, 8'h00, 14'h2400, {3{14'h2400}}},
        '{8'h00, 8'h00, 8'h08, 8'h20, 14'h2000, {3{14'h3FF}}},
        '{8'h00, 8'h00, 8'h00, 8'h20, 14'h2000, {3{14'h400}}}
    };
    logic [7:0] m_addr [6] = '{8'h2B, 8'h3D, 8'h3F, 8'h42, 8'h44, 8'h50};
    logic [7:0] m_exp  [6] = '{8'hFF, 8'h20, 8'h3F, 8'h0F, 8'hC5, 8'h00};
    logic [7:0] m_wr   [6] = '{8'hFF, 8'h20, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] r_addr [9] = '{8'h2B, 8'h25, 8'h37, 8'h31, 8'h3D, 8'h3F,
                               8'h40, 8'h42, 8'h44};

    acgtp_top u_acgtp_top (
        .SYS_CLK_IN    (sys_clk),
        .RST_IN        (rst),
        .SAMPLE_CLK_IN (smp_clk),
        .REG_ADDR_IN   (addr),
        .REG_WDATA_IN  (wdata),
        .REG_WR_IN     (wr_en),
        .REG_RDATA_OUT (rdata),
        .ADC_DATA_IN   (adc),
        .CH_DATA_OUT   (dout),
        .CH_VALID_OUT  (valid)
    );

    acgtp_rx_model u_acgtp_rx_model (
        .clk_in    (sys_clk),
        .rst_in    (rst),
        .valid_in  (valid),
        .data_in   (dout),
        .word_out  (rx_word),
        .count_out (rx_count)
    );

    // ========================================================
    // clocks and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // sample clock stands still low while the bench reconfigures
    initial begin
        smp_clk = 1'b0;
        #3.3;
        forever begin
            #16;
            smp_clk = smp_run ? ~smp_clk : 1'b0;
        end
    end

    initial begin
        #100000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    // ========================================================
    // tasks
    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge sys_clk);
        #1;
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        #1;
        addr = a;
        @(posedge sys_clk);
        #1;
        chk({48'h0, rdata}, {48'h0, exp});
    endtask

    task automatic get_word(output logic [55:0] wd);
        logic [31:0] c0;
        int          n;
        c0 = rx_count;
        n = 0;
        while (rx_count === c0 && n < 60) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 60) begin
            err_count++;
            $display("[FAIL] %0t no sample arrived", $time);
        end
        wd = rx_word;
    endtask

    task automatic run_cfg(input acgtp_row_t r);
        smp_run = 1'b0;
        repeat (20) @(posedge sys_clk);
        wr(OFS_BURST, r.b);
        wr(OFS_DIG_EN, r.d);
        wr(OFS_MIDFIX, r.m);
        for (int j = 0; j < NUM_CH; j++) wr(OFS_CHAN[j], r.c);
        adc = {4{r.a}};
        smp_run = 1'b1;
    endtask

    // ========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        smp_run = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        adc = '0;
        err_count = 0;
        check_count = 0;
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk(dout, 56'h0);
        chk({55'h0, valid}, 56'h0);
        for (int i = 0; i < 9; i++) rd(r_addr[i], RST_VAL);
        wr(OFS_PAT_HI, 8'h2A);
        wr(OFS_PAT_LO, 8'h5C);
        wr(8'hCF, 8'h08);
        for (int i = 0; i < 17; i++) begin
            run_cfg(rows[i]);
            for (int k = 2; k >= 0; k--) begin
                get_word(w);
                chk(w, {4{rows[i].e[k]}});
            end
        end
        smp_run = 1'b0;
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            wr(m_addr[i], m_wr[i]);
            rd(m_addr[i], m_exp[i]);
        end
        run_cfg('{8'h04, 8'h00, 8'h00, 8'h00, 14'h2400, {3{14'h0}}});
        for (int k = 0; k < 9; k++) begin
            get_word(w);
            chk(w, {4{(k == 8) ? 14'h0001 : 14'h0000}});
        end
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(dout, 56'h0);
        chk({55'h0, valid}, 56'h0);
        rst = 1'b0;
        smp_run = 1'b0;
        rd(OFS_CHAN[0], RST_VAL);
        give_verdict();
    end
endmodule // test_acgtp_top
`default_nettype wire
